//--- core/bus_config_defines.vh
// What this block does
// [R1] power-up loads bus configuration with 9d1f
// [R2] select pin high, address 10 picks register
// [R3] third write data 0001 targets bus configuration
// [R4] third data 0000/0001/0002 picks refresh/bus/identification
// [R5] bit 15: 0 synchronous burst, 1 asynchronous
// [R6] bit 14: 0 variable, 1 fixed latency
// [R7] bits 13-11 codes 010-110 give latency 2-6
// [R8] bit 10 sets wait indicator polarity
// [R9] bit 8: wait during delay or one early
// [R10] bit 3: 0 wrap, 1 linear burst
// [R11] bits 2-0 give 4/8/16/32 or continuous
// [R12] length and wrap govern reads and writes
// [R13] continuous burst runs to the row end
// [R14] linear fixed burst stops at row end
// [R15] wrap steps low bits inside aligned block
// [R16] select pin low routes operations to array
// [R17] software sequence: two reads, two writes, top
// [R18] controller writes zero into reserved bits
// [R19] register holds value, reads back unchanged
//
// Purpose: constants of the bus configuration block
// Assumes: 16-bit data, 22-bit word address
// Notes:   included by core/bus_config.v
`ifndef BUS_CONFIG_DEFINES_VH
`define BUS_CONFIG_DEFINES_VH

// ****************************************
// reset values
// ****************************************
`define BCFG_RESET      16'h9d1f
`define RCFG_RESET      16'h0010
// identification value is arbitrary
`define IDENT_VALUE     16'h0a5c

// ****************************************
// register select by address
// ****************************************
`define SEL_HI          19
`define SEL_LO          18
`define SEL_RCFG        2'b00
`define SEL_IDENT       2'b01
`define SEL_BCFG        2'b10

// ****************************************
// software sequence
// ****************************************
`define SW_ADDR         22'h3fffff
`define SW_RCFG         16'h0000
`define SW_BCFG         16'h0001
`define SW_IDENT        16'h0002

// ****************************************
// bus configuration fields
// ****************************************
`define F_MODE          15
`define F_LAT_TYPE      14
`define F_LAT_HI        13
`define F_LAT_LO        11
`define F_WAIT_POL      10
`define F_WAIT_CFG      8
`define F_WRAP_OFF      3
`define F_BL_HI         2
`define F_BL_LO         0
`define LAT_MIN         3'h2
`define LAT_MAX         3'h6
`define LAT_DEFAULT     3'h3
`define BL_4            3'h1
`define BL_8            3'h2
`define BL_16           3'h3
`define BL_32           3'h4

// ****************************************
// geometry
// ****************************************
`define ADDR_W          22
`define DATA_W          16
`define ROW_BITS        8
`define FIFO_DEPTH      16
`define FIFO_AW         4

`endif

//--- core/word_fifo.v
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two, aw = log2(depth)
// Notes:   full and empty come straight from the count
`default_nettype none

module word_fifo #(
  parameter W     = 39,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire         clock,
  input  wire         nrst,
  // filling side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // draining side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

//--- core/bus_config.v
// Purpose: bus configuration register and burst address sequencer
// Assumes: pins are asynchronous to clock and pass two flip-flops
// Notes:   array operations leave through a 16-word fifo
`include "bus_config_defines.vh"
`default_nettype none

module bus_config (
  // clock and reset
  input  wire                clock,
  input  wire                nrst,
  // memory pins
  input  wire                register_space_select,
  input  wire                ce_n,
  input  wire                we_n,
  input  wire                oe_n,
  input  wire                adv_n,
  input  wire [`ADDR_W-1:0]  addr,
  input  wire [`DATA_W-1:0]  dq_in,
  output wire [`DATA_W-1:0]  dq_out,
  output wire                dq_oe,
  output wire                wait_out,
  output wire                wait_oe,
  // array operation stream
  output wire                array_valid,
  input  wire                array_ready,
  output wire                array_we,
  output wire [`ADDR_W-1:0]  array_addr,
  output wire [`DATA_W-1:0]  array_wdata,
  // decoded configuration
  output wire [`DATA_W-1:0]  bus_configuration,
  output wire                sync_mode,
  output wire                fixed_latency,
  output wire [2:0]          latency_count,
  output wire                wrap_enable,
  output wire [5:0]          burst_words
);

  // ****************************************
  // states
  // ****************************************
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_READ1 = 4'b0010;
  localparam [3:0] S_READ2 = 4'b0100;
  localparam [3:0] S_WRITE = 4'b1000;

  // ****************************************
  // functions
  // ****************************************
  function [5:0] burst_len;
    input [2:0] code;
    begin
      case (code)
        `BL_4:   burst_len = 6'h04;
        `BL_8:   burst_len = 6'h08;
        `BL_16:  burst_len = 6'h10;
        `BL_32:  burst_len = 6'h20;
        default: burst_len = 6'h00;
      endcase
    end
  endfunction

  function [2:0] lat_value;
    input [2:0] code;
    begin
      if (code >= `LAT_MIN && code <= `LAT_MAX) begin
        lat_value = code;
      end else begin
        lat_value = `LAT_DEFAULT;
      end
    end
  endfunction

  function [`ADDR_W-1:0] next_addr;
    input [`ADDR_W-1:0] a;
    input [5:0]         len;
    input               wrap;
    reg   [5:0]         t;
    reg   [4:0]         m;
    reg   [4:0]         inc;
    begin
      t   = len - 6'h01;
      m   = t[4:0];
      inc = a[4:0] + 5'h01;
      if (wrap && len != 6'h00) begin
        next_addr = {a[`ADDR_W-1:5], (a[4:0] & ~m) | (inc & m)}; // [R15]
      end else begin
        next_addr = a + 22'h000001; // [R14]
      end
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [4:0]                  ctl_m_q;
  reg [4:0]                  ctl_s_q;
  reg [`ADDR_W+`DATA_W-1:0]  dat_m_q;
  reg [`ADDR_W+`DATA_W-1:0]  dat_s_q;
  reg                        ce_prev_q;
  wire                       cre_s;
  wire                       adv_s_n;
  wire                       oe_s_n;
  wire                       we_s_n;
  wire                       ce_s_n;
  wire [`ADDR_W-1:0]         addr_s;
  wire [`DATA_W-1:0]         dq_s;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl_m_q   <= 5'h0f;
      ctl_s_q   <= 5'h0f;
      dat_m_q   <= {(`ADDR_W+`DATA_W){1'b0}};
      dat_s_q   <= {(`ADDR_W+`DATA_W){1'b0}};
      ce_prev_q <= 1'b1;
    end else begin
      ctl_m_q   <= {register_space_select, adv_n, oe_n, we_n, ce_n};
      ctl_s_q   <= ctl_m_q;
      dat_m_q   <= {addr, dq_in};
      dat_s_q   <= dat_m_q;
      ce_prev_q <= ce_s_n;
    end
  end

  assign {cre_s, adv_s_n, oe_s_n, we_s_n, ce_s_n} = ctl_s_q;
  assign {addr_s, dq_s} = dat_s_q;

  // ****************************************
  // operation capture
  // ****************************************
  reg                  op_wr_q;
  reg                  op_cre_q;
  reg [`ADDR_W-1:0]    op_addr_q;
  reg [`DATA_W-1:0]    op_dq_q;
  wire                 op_start;
  wire                 op_end;
  wire                 sw_hit;

  assign op_start = ce_prev_q & ~ce_s_n;
  assign op_end   = ~ce_prev_q & ce_s_n;
  assign sw_hit   = ~op_cre_q && (op_addr_q == `SW_ADDR);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      op_wr_q   <= 1'b0;
      op_cre_q  <= 1'b0;
      op_addr_q <= {`ADDR_W{1'b0}};
      op_dq_q   <= {`DATA_W{1'b0}};
    end else if (!ce_s_n) begin
      op_wr_q   <= (op_start ? 1'b0 : op_wr_q) | ~we_s_n;
      op_cre_q  <= cre_s;
      op_addr_q <= addr_s;
      op_dq_q   <= dq_s;
    end
  end

  // ****************************************
  // registers and software sequence
  // ****************************************
  reg [`DATA_W-1:0]  bcfg_q;
  reg [`DATA_W-1:0]  rcfg_q;
  reg [3:0]          st_q;
  reg [3:0]          st_d;
  reg [1:0]          sw_sel_q;
  reg [1:0]          sw_sel_d;
  reg                wr_en;
  reg [1:0]          wr_sel;
  reg [`DATA_W-1:0]  wr_data;

  function [`DATA_W-1:0] reg_read;
    input [1:0] sel;
    begin
      case (sel)
        `SEL_BCFG:  reg_read = bcfg_q; // [R19]
        `SEL_RCFG:  reg_read = rcfg_q;
        `SEL_IDENT: reg_read = `IDENT_VALUE;
        default:    reg_read = {`DATA_W{1'b0}};
      endcase
    end
  endfunction

  always @* begin
    st_d     = st_q;
    sw_sel_d = sw_sel_q;
    wr_en    = 1'b0;
    wr_sel   = `SEL_BCFG;
    wr_data  = op_dq_q;
    if (op_end) begin
      if (op_cre_q && op_wr_q) begin
        wr_en   = 1'b1; // [R2]
        wr_sel  = op_addr_q[`SEL_HI:`SEL_LO];
        wr_data = op_addr_q[`DATA_W-1:0];
      end
      if (!sw_hit) begin
        st_d = S_IDLE; // [R17]
      end else begin
        case (st_q)
          S_IDLE:  st_d = op_wr_q ? S_IDLE : S_READ1;
          S_READ1: st_d = op_wr_q ? S_IDLE : S_READ2;
          S_READ2: begin
            st_d = S_IDLE;
            if (op_wr_q) begin
              st_d = S_WRITE;
              case (op_dq_q) // [R4]
                `SW_RCFG:  sw_sel_d = `SEL_RCFG;
                `SW_BCFG:  sw_sel_d = `SEL_BCFG; // [R3]
                `SW_IDENT: sw_sel_d = `SEL_IDENT;
                default:   st_d = S_IDLE;
              endcase
            end
          end
          S_WRITE: begin
            st_d = S_IDLE;
            if (op_wr_q) begin
              wr_en  = 1'b1; // [R3]
              wr_sel = sw_sel_q;
            end
          end
          default: st_d = S_IDLE;
        endcase
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bcfg_q   <= `BCFG_RESET; // [R1]
      rcfg_q   <= `RCFG_RESET;
      st_q     <= S_IDLE;
      sw_sel_q <= `SEL_BCFG;
    end else begin
      st_q     <= st_d;
      sw_sel_q <= sw_sel_d;
      if (wr_en && wr_sel == `SEL_BCFG) begin
        bcfg_q <= wr_data; // [R19]
      end
      if (wr_en && wr_sel == `SEL_RCFG) begin
        rcfg_q <= wr_data;
      end
    end
  end

  // ****************************************
  // decoded fields
  // ****************************************
  assign bus_configuration = bcfg_q;
  assign sync_mode     = ~bcfg_q[`F_MODE]; // [R5]
  assign fixed_latency = bcfg_q[`F_LAT_TYPE]; // [R6]
  assign latency_count = lat_value(bcfg_q[`F_LAT_HI:`F_LAT_LO]); // [R7]
  assign wrap_enable   = ~bcfg_q[`F_WRAP_OFF]; // [R10]
  assign burst_words   = burst_len(bcfg_q[`F_BL_HI:`F_BL_LO]); // [R11]

  // ****************************************
  // register read drive
  // ****************************************
  reg [`DATA_W-1:0]  dq_out_q;
  reg                dq_oe_q;
  wire               sw_rd;

  assign sw_rd = (st_q == S_WRITE) && ~cre_s && (addr_s == `SW_ADDR);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dq_out_q <= {`DATA_W{1'b0}};
      dq_oe_q  <= 1'b0;
    end else begin
      dq_oe_q  <= ~ce_s_n & ~oe_s_n & we_s_n & (cre_s | sw_rd);
      if (cre_s) begin
        dq_out_q <= reg_read(addr_s[`SEL_HI:`SEL_LO]); // [R2]
      end else begin
        dq_out_q <= reg_read(sw_sel_q); // [R3]
      end
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe  = dq_oe_q;

  // ****************************************
  // burst sequencer
  // ****************************************
  reg                 busy_q;
  reg [`ADDR_W-1:0]   cur_q;
  reg [5:0]           cnt_q;
  reg [2:0]           lat_q;
  reg                 dir_q;
  reg                 pend_q;
  reg                 slot_v_q;
  reg [`ADDR_W+`DATA_W:0] slot_q;
  reg                 wait_q;
  reg                 wait_oe_q;
  wire                fifo_ready;
  wire                slot_free;
  wire                row_end;
  wire                burst_last;
  wire                burst_go;
  wire                delay;
  wire                async_fwd;
  wire                wait_early;

  assign slot_free  = ~slot_v_q | fifo_ready;
  assign row_end    = &cur_q[`ROW_BITS-1:0];
  assign burst_go   = busy_q && lat_q == 3'h0 && slot_free && ~ce_s_n;
  assign burst_last = (burst_words == 6'h00) ? row_end : // [R13]
                      (wrap_enable ? (cnt_q == burst_words - 6'h01)
                                   : (row_end ||
                                      cnt_q == burst_words - 6'h01));
  assign async_fwd  = op_end && ~sync_mode && ~op_cre_q && // [R16]
                      !(sw_hit && (st_q == S_READ2 || st_q == S_WRITE));
  assign delay      = busy_q && (wait_early ? (lat_q > 3'h1 || ~slot_free)
                                            : (lat_q != 3'h0 || ~slot_free));

  assign wait_early = bcfg_q[`F_WAIT_CFG]; // [R9]

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_q    <= 1'b0;
      cur_q     <= {`ADDR_W{1'b0}};
      cnt_q     <= 6'h00;
      lat_q     <= 3'h0;
      dir_q     <= 1'b0;
      pend_q    <= 1'b0;
      slot_v_q  <= 1'b0;
      slot_q    <= {(`ADDR_W+`DATA_W+1){1'b0}};
      wait_q    <= 1'b0;
      wait_oe_q <= 1'b0;
    end else begin
      if (fifo_ready) begin
        slot_v_q <= 1'b0;
      end
      if (async_fwd) begin
        pend_q <= 1'b1;
      end
      if (op_start && sync_mode && ~cre_s && ~adv_s_n) begin
        busy_q <= 1'b1;
        cur_q  <= addr_s;
        cnt_q  <= 6'h00;
        lat_q  <= latency_count;
        dir_q  <= ~we_s_n; // [R12]
      end else if (busy_q && ce_s_n) begin
        busy_q <= 1'b0;
      end else if (busy_q && lat_q != 3'h0) begin
        lat_q <= lat_q - 3'h1;
      end else if (burst_go) begin
        slot_v_q <= 1'b1;
        slot_q   <= {dir_q, cur_q, dq_s}; // [R12]
        cnt_q    <= cnt_q + 6'h01;
        cur_q    <= next_addr(cur_q, burst_words, wrap_enable);
        if (burst_last) begin
          busy_q <= 1'b0;
        end
      end
      if (pend_q && slot_free && !burst_go) begin
        pend_q   <= 1'b0;
        slot_v_q <= 1'b1;
        slot_q   <= {op_wr_q, op_addr_q, op_dq_q}; // [R16]
      end
      wait_oe_q <= sync_mode & ~ce_s_n & ~cre_s;
      wait_q    <= bcfg_q[`F_WAIT_POL] ? delay : ~delay; // [R8]
    end
  end

  assign wait_out = wait_q;
  assign wait_oe  = wait_oe_q;

  // ****************************************
  // array fifo
  // ****************************************
  word_fifo #(
    .W     (`ADDR_W+`DATA_W+1),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (slot_v_q),
    .in_ready  (fifo_ready),
    .in_data   (slot_q),
    .out_valid (array_valid),
    .out_ready (array_ready),
    .out_data  ({array_we, array_addr, array_wdata})
  );

endmodule

`default_nettype wire

//--- testbench/bus_config_assertions.sv
// Purpose: assertions on the ports of bus_config
// Assumes: bound into every bus_config instance
// Notes:   ce_hi_q counts cycles since ce_n went high
`default_nettype none
module bus_config_assertions (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // pins
  input wire logic        ce_n,
  input wire logic        dq_oe,
  input wire logic        wait_oe,
  // array stream
  input wire logic        array_valid,
  input wire logic        array_ready,
  input wire logic [21:0] array_addr,
  // configuration
  input wire logic [15:0] bus_configuration,
  input wire logic        sync_mode,
  input wire logic        fixed_latency,
  input wire logic [2:0]  latency_count,
  input wire logic        wrap_enable,
  input wire logic [5:0]  burst_words
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // helpers and assertions
  // ****************************************
  logic [3:0]  ce_hi_q;
  logic [21:0] last_q;
  logic        take_q;
  wire         take = array_valid && array_ready;
  wire [2:0]   lc = bus_configuration[13:11];
  wire [2:0]   bl = bus_configuration[2:0];
  wire [5:0]   bw = (bl == 3'h1) ? 6'h04 : (bl == 3'h2) ? 6'h08 :
                    (bl == 3'h3) ? 6'h10 : (bl == 3'h4) ? 6'h20 : 6'h00;
  wire [21:0]  m = {16'h0000, burst_words} - 22'h000001;
  wire [21:0]  nxt = (wrap_enable && burst_words != 6'h00) ?
                     ((last_q & ~m) | ((last_q + 22'h000001) & m)) :
                     (last_q + 22'h000001);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ce_hi_q <= 4'hf;
      take_q <= 1'b0;
      last_q <= 22'h000000;
    end else begin
      ce_hi_q <= !ce_n ? 4'h0 : (ce_hi_q == 4'hf) ? ce_hi_q : ce_hi_q + 4'h1;
      take_q <= take;
      if (take)
        last_q <= array_addr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  reset_value_a: assert property ($rose(nrst) |->
    bus_configuration == 16'h9d1f) else $error("bad reset value");
  mode_decode_a: assert property (sync_mode == !bus_configuration[15]
    && fixed_latency == bus_configuration[14]) else $error("bad mode");
  latency_decode_a: assert property (latency_count ==
    ((lc >= 3'h2 && lc <= 3'h6) ? lc : 3'h3)) else $error("bad latency");
  wrap_decode_a: assert property (wrap_enable == !bus_configuration[3])
    else $error("bad wrap");
  length_decode_a: assert property (burst_words == bw)
    else $error("bad burst length");
  reg_hold_a: assert property ($changed(bus_configuration) |->
    ce_hi_q inside {[1:8]}) else $error("register changed");
  burst_order_a: assert property (take && take_q |->
    array_addr == nxt) else $error("bad burst order");
  wait_scope_a: assert property (wait_oe |-> ce_hi_q < 4'h6)
    else $error("wait driven while idle");
  read_drive_a: assert property (dq_oe |-> !wait_oe && ce_hi_q < 4'h6)
    else $error("bad data drive");
  cover property (take && take_q && wrap_enable);
  cover property (dq_oe);
  cover property (wait_oe && array_valid && !array_ready);
  cover property ($changed(bus_configuration));
endmodule
bind bus_config bus_config_assertions chk (.clock(clock), .nrst(nrst),
  .ce_n(ce_n), .dq_oe(dq_oe), .wait_oe(wait_oe),
  .array_valid(array_valid), .array_ready(array_ready),
  .array_addr(array_addr), .bus_configuration(bus_configuration),
  .sync_mode(sync_mode), .fixed_latency(fixed_latency),
  .latency_count(latency_count), .wrap_enable(wrap_enable),
  .burst_words(burst_words));
`default_nettype wire

//--- testbench/array_sink.sv
// Purpose: consumer of the array operation stream
// Assumes: stall held by the bench
// Notes:   keeps the last 64 accepted entries in order
`default_nettype none
module array_sink (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // array stream
  input wire logic        array_valid,
  output logic            array_ready,
  input wire logic        array_we,
  input wire logic [21:0] array_addr,
  input wire logic [15:0] array_wdata,
  // bench control
  input wire logic        stall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [21:0] got_addr [0:63];
  logic [15:0] got_data [0:63];
  logic        got_we [0:63];
  int          n;
  assign array_ready = !stall;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      n <= 0;
    end else if (array_valid && array_ready) begin
      got_addr[n[5:0]] <= array_addr;
      got_data[n[5:0]] <= array_wdata;
      got_we[n[5:0]] <= array_we;
      n <= n + 1;
    end
  end
endmodule
`default_nettype wire

//--- testbench/bus_config_test.sv
// Purpose: self-checking bench of bus_config
// Assumes: pins change at the falling edge
// Notes:   array entries collected by array_sink
`include "bus_config_defines.vh"
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end end
module bus_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock, nrst, register_space_select, ce_n, stall;
  logic             we_n, oe_n, adv_n;
  logic [21:0]      addr;
  logic [15:0]      dq_in, q, v;
  logic             qe;
  logic [21:0]      wexp [4] = '{22'h6, 22'h7, 22'h4, 22'h5};
  wire logic [15:0] dq_out, bus_configuration, array_wdata;
  wire logic [21:0] array_addr;
  wire logic [5:0]  burst_words;
  wire logic [2:0]  latency_count;
  wire logic        dq_oe, wait_out, wait_oe, array_valid, array_ready;
  wire logic        array_we, sync_mode, fixed_latency, wrap_enable;
  int               n_mismatch, cmp_count, cyc, base;
  bus_config dut (.clock(clock), .nrst(nrst),
    .register_space_select(register_space_select), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .adv_n(adv_n), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .wait_out(wait_out), .wait_oe(wait_oe), .array_valid(array_valid),
    .array_ready(array_ready), .array_we(array_we),
    .array_addr(array_addr), .array_wdata(array_wdata),
    .bus_configuration(bus_configuration), .sync_mode(sync_mode),
    .fixed_latency(fixed_latency), .latency_count(latency_count),
    .wrap_enable(wrap_enable), .burst_words(burst_words));
  array_sink sink (.clock(clock), .nrst(nrst), .array_valid(array_valid),
    .array_ready(array_ready), .array_we(array_we),
    .array_addr(array_addr), .array_wdata(array_wdata), .stall(stall));
  // ****************************************
  // pin tasks
  // ****************************************
  task automatic start(input logic s, w, b, input logic [21:0] a,
                       input logic [15:0] d);
    @(negedge clock);
    register_space_select = s;
    ce_n = 1'b0;
    we_n = !w;
    oe_n = w;
    adv_n = !b;
    addr = a;
    dq_in = d;
  endtask
  task automatic stop();
    q = dq_out;
    qe = dq_oe;
    {ce_n, we_n, oe_n, adv_n} = 4'hf;
    dq_in = ~dq_in;
    repeat (6) @(negedge clock);
  endtask
  task automatic op(input logic s, w, b, input logic [21:0] a,
                    input logic [15:0] d, input int h);
    start(s, w, b, a, d);
    repeat (h) @(negedge clock);
    stop();
  endtask
  task automatic wr_reg(input logic [1:0] r, input logic [15:0] d);
    op(1'b1, 1'b1, 1'b0, {2'h0, r, 2'h0, d}, 16'h0000, 6);
  endtask
  task automatic rd_reg(input logic [1:0] r);
    op(1'b1, 1'b0, 1'b0, {2'h0, r, 18'h00000}, 16'h0000, 6);
  endtask
  task automatic sw(input logic [15:0] c, input logic w,
                    input logic [15:0] d);
    op(1'b0, 1'b0, 1'b0, `SW_ADDR, 16'h0000, 6);
    op(1'b0, 1'b0, 1'b0, `SW_ADDR, 16'h0000, 6);
    op(1'b0, 1'b1, 1'b0, `SW_ADDR, c, 6);
    op(1'b0, w, 1'b0, `SW_ADDR, d, 6);
  endtask
  function automatic logic [5:0] bw(input logic [2:0] c);
    return (c == 3'h1) ? 6'h04 : (c == 3'h2) ? 6'h08 : (c == 3'h3) ?
      6'h10 : (c == 3'h4) ? 6'h20 : 6'h00;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // clock, timeout and tests
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    {nrst, register_space_select, stall, addr, dq_in} = '0;
    {ce_n, we_n, oe_n, adv_n} = 4'hf;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    rd_reg(2'h2);
    `CHK("reset value", `BCFG_RESET, q)
    `CHK("read drive", 1'b1, qe)
    `CHK("fixed latency", 1'b0, fixed_latency)
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      logic [2:0] c;
      c = k[2:0];
      v = {c[1], c[0], c, 7'h51, c[2], c};
      wr_reg(2'h2, v);
      rd_reg(2'h2);
      `CHK("readback", v, q)
      `CHK("config", v, bus_configuration)
      `CHK("sync mode", !c[1], sync_mode)
      `CHK("fixed latency", c[0], fixed_latency)
      `CHK("latency", (c >= 3'h2 && c <= 3'h6) ? c : 3'h3, latency_count)
      `CHK("wrap", !c[2], wrap_enable)
      `CHK("burst words", bw(c), burst_words)
    end
    $display("test decode done");
    sw(16'h0000, 1'b1, 16'h0080);
    `CHK("sw write drive", 1'b0, qe)
    rd_reg(2'h0);
    `CHK("refresh value", 16'h0080, q)
    sw(16'h0002, 1'b0, 16'h0000);
    `CHK("ident value", `IDENT_VALUE, q)
    `CHK("ident drive", 1'b1, qe)
    sw(16'h0001, 1'b1, `BCFG_RESET);
    rd_reg(2'h2);
    `CHK("sw write", `BCFG_RESET, q)
    sw(16'h0001, 1'b0, 16'h0000);
    `CHK("sw read", `BCFG_RESET, q)
    $display("test software done");
    base = sink.n;
    op(1'b0, 1'b1, 1'b0, 22'h000123, 16'hbeef, 6);
    wr_reg(2'h2, 16'h1d11);
    `CHK("array count", base + 1, sink.n)
    `CHK("array addr", 22'h000123, sink.got_addr[base])
    `CHK("array data", 16'hbeef, sink.got_data[base])
    $display("test array done");
    for (int w = 0; w < 2; w++) begin
      base = sink.n;
      op(1'b0, w[0], 1'b1, 22'h000006, 16'h1234, 14);
      `CHK("wrap count", base + 4, sink.n)
      for (int i = 0; i < 4; i++) begin
        `CHK("wrap addr", wexp[i], sink.got_addr[base + i])
        `CHK("burst dir", w[0], sink.got_we[base + i])
      end
    end
    wr_reg(2'h2, 16'h1d19);
    base = sink.n;
    start(1'b0, 1'b0, 1'b1, 22'h0000fe, 16'h0000);
    repeat (5) @(negedge clock);
    `CHK("wait latency", 1'b1, wait_out)
    @(negedge clock);
    `CHK("wait early", 1'b0, wait_out)
    repeat (8) @(negedge clock);
    stop();
    `CHK("linear count", base + 2, sink.n)
    `CHK("linear last", 22'h0000ff, sink.got_addr[base + 1])
    wr_reg(2'h2, 16'h1d1f);
    base = sink.n;
    stall = 1'b1;
    start(1'b0, 1'b0, 1'b1, 22'h0000e0, 16'h0000);
    repeat (30) @(negedge clock);
    `CHK("stalled", base, sink.n)
    `CHK("full valid", 1'b1, array_valid)
    `CHK("wait level", 1'b1, wait_out)
    `CHK("wait drive", 1'b1, wait_oe)
    stall = 1'b0;
    repeat (40) @(negedge clock);
    stop();
    `CHK("row count", base + 32, sink.n)
    for (int i = 0; i < 32; i++)
      `CHK("row addr", 22'h0000e0 + i, sink.got_addr[base + i])
    `CHK("drained", 1'b0, array_valid)
    $display("test bursts done");
    wrap_up();
  end
endmodule
`default_nettype wire
